// >>> acm_pkg.sv
// register map, field positions, reset values and cycle counts of the
// converter post-processing and sequencing block
// assumes one 40 MHz clock and register access over the serial port only
package acm_pkg;
	localparam logic [3:0] REG_RESULT = 4'h0;
	localparam logic [3:0] REG_CONTROL = 4'h1;
	localparam logic [3:0] REG_THIRD_CONFIG_REGISTER = 4'h3;
	localparam logic [3:0] REG_TIMER = 4'h7;
	localparam logic [3:0] REG_OFFSET = 4'h9;
	localparam logic [3:0] REG_GAIN = 4'hA;
	localparam logic [3:0] REG_STATUS = 4'hB;
	localparam logic [1:0] CMD_READ = 2'h1;
	localparam logic [1:0] CMD_WRITE = 2'h2;
	localparam logic [1:0] MODE_SHUT = 2'h0;
	localparam logic [1:0] MODE_STANDBY = 2'h2;
	localparam logic [1:0] MODE_CONV = 2'h3;
	localparam int CFG_CONV_LSB = 6;
	localparam int CFG_OFF_EN = 1;
	localparam int CFG_GAIN_EN = 0;
	localparam int CTL_AZ = 2;
	localparam int CTL_SCAN = 3;
	localparam int CTL_LAST_LSB = 4;
	localparam logic [7:0] THIRD_CONFIG_REGISTER_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [23:0] OFFSET_RESET = 24'h000000;
	localparam logic [23:0] GAIN_RESET = 24'h800000;
	localparam logic [23:0] TIMER_RESET = 24'h000000;
	localparam logic [23:0] STARTUP_CYCLES = 24'h000100;
	localparam logic [23:0] CONV_CYCLES = 24'h000400;
	localparam logic [3:0] GAIN_LAST_BIT = 4'hF;
	localparam int GAIN_FRAC = 15;
	localparam logic [5:0] CMD_BITS = 6'h08;
	localparam logic [5:0] BITS_8 = 6'h08;
	localparam logic [5:0] BITS_16 = 6'h10;
	localparam logic [5:0] BITS_24 = 6'h18;
	localparam logic [4:0] IRQ_HOLD = 5'h10;
	localparam logic signed [33:0] SAT_HI = 34'sh000007FFF;
	localparam logic signed [33:0] SAT_LO = 34'sh3FFFF8000;
	localparam int RAW_W = 16;
	localparam int FIFO_DEPTH = 16;
	typedef enum logic [4:0] {
		ST_SHUT = 5'h01,
		ST_WARM = 5'h02,
		ST_IDLE = 5'h04,
		ST_CONV = 5'h08,
		ST_GAP = 5'h10
	} acm_state_t;
endpackage

// >>> acm_core.sv
// raw sample buffer, offset/gain correction, conversion sequencer and serial
// register port of the converter
// assumes raw samples, serial pins and reset are synchronous to clock
// Function
// - both corrections on: result is (raw plus offset) times gain
// - a cleared enable skips its correction and ignores its register
// - guard bits carried; only the final result is checked for overload
// - offset register is 24-bit signed at address 0x9
// - offset uses bits 23:8 only; low byte taken as zero
// - offset is a 16-bit signed add with no added latency
// - offset changes leave held result alone; apply from next result
// - gain register is unsigned 24-bit at 0xA, upper 16 bits over 32768
// - gain uses bits 23:8 only; low byte taken as zero
// - gain add-and-shift delays data ready 15 clocks, not conversions
// - gain changes leave held result alone; apply from next result
// - mode 0x: one conversion, then shutdown, state field back to 0x
// - mode 10: one conversion or scan cycle, then standby, state 10
// - mode 11 single channel: convert continuously, state stays 11
// - scan mode 11 repeats cycles with timer gap; 0x runs one cycle
// - one-shot lasts one conversion time, doubled with auto-zero swap
// - one-shot data ready stays until host reads the whole result
// - continuous: first result after one conversion time, no filter reset
// - auto-zero swap makes continuous into reset one-shots, half rate
// - start from shutdown waits 256 clocks; shutdown reloads the count
module acm_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem[rd_ptr];
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= next_count;
			in_ready <= next_count != (AW+1)'(DEPTH);
			out_valid <= next_count != '0;
		end
	end
	always_ff @(posedge clock) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule

module acm_core #(
	parameter logic [23:0] conv_cycles = acm_pkg::CONV_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	input wire logic [acm_pkg::RAW_W-1:0] raw_data,
	input wire logic raw_valid,
	output logic raw_ready,
	output logic modulator_enable,
	output logic conversion_strobe,
	output logic filter_clear,
	output logic data_ready_n,
	output logic overload
);
	import acm_pkg::*;

	function automatic logic [5:0] reg_bits(input logic [3:0] a);
		case (a)
			REG_RESULT: reg_bits = BITS_16;
			REG_TIMER, REG_OFFSET, REG_GAIN: reg_bits = BITS_24;
			default: reg_bits = BITS_8;
		endcase
	endfunction

	function automatic logic signed [33:0] gain_term(input logic signed [16:0] s, input logic [15:0] g,
		input logic [3:0] i);
		logic signed [33:0] ext;
		ext = 34'(s);
		gain_term = g[i] ? (ext <<< i) : '0;
	endfunction

	function automatic logic [16:0] sat16(input logic signed [33:0] v);
		if (v > SAT_HI)
			sat16 = {1'b1, 16'h7FFF};
		else if (v < SAT_LO)
			sat16 = {1'b1, 16'h8000};
		else
			sat16 = {1'b0, v[15:0]};
	endfunction

	// serial port
	logic sclk_q;
	logic [5:0] bit_cnt;
	logic [7:0] cmd;
	logic [23:0] shift_in;
	logic [23:0] shift_out;
	logic [23:0] read_word;
	// registers
	logic [7:0] third_config_register;
	logic [23:0] offset_correction_value;
	logic [23:0] gain_correction_value;
	logic [23:0] scan_timer;
	logic [1:0] adc_mode;
	logic auto_zero_swap_enable;
	logic scan_en;
	logic [3:0] scan_last;
	logic [15:0] conversion_result;
	// sequencer
	acm_state_t state;
	acm_state_t next_state;
	logic [23:0] cnt;
	logic [23:0] next_cnt;
	logic [3:0] scan_idx;
	// datapath
	logic gain_busy;
	logic [3:0] bit_i;
	logic signed [16:0] sum_q;
	logic [15:0] g_q;
	logic signed [33:0] acc;
	logic [4:0] hold;
	logic fifo_valid;
	logic [15:0] fifo_data;

	wire rise = spi_sclk && !sclk_q && !spi_cs_n;
	wire fall = !spi_sclk && sclk_q && !spi_cs_n;
	wire [24:0] in_word = {shift_in, spi_mosi};
	wire [3:0] rd_addr = in_word[5:2];
	wire [3:0] cmd_addr = cmd[5:2];
	wire wr_fire = rise && cmd[1:0] == CMD_WRITE && bit_cnt == CMD_BITS - 6'h01 + reg_bits(cmd_addr);
	wire rd_done = rise && cmd[1:0] == CMD_READ && cmd_addr == REG_RESULT
		&& bit_cnt == CMD_BITS - 6'h01 + BITS_16;
	wire ctl_wr = wr_fire && cmd_addr == REG_CONTROL;
	wire [1:0] conversion_sequencing_select = third_config_register[CFG_CONV_LSB +: 2];

	assign read_word = rd_addr == REG_RESULT ? {8'h00, conversion_result}
		: rd_addr == REG_CONTROL ? {16'h0000, scan_last, scan_en, auto_zero_swap_enable, adc_mode}
		: rd_addr == REG_THIRD_CONFIG_REGISTER ? {16'h0000, third_config_register}
		: rd_addr == REG_TIMER ? scan_timer
		: rd_addr == REG_OFFSET ? offset_correction_value
		: rd_addr == REG_GAIN ? gain_correction_value
		: rd_addr == REG_STATUS ? {16'h0000, state, 1'b0, overload, !data_ready_n}
		: 24'h000000;
	wire [23:0] read_aligned = in_word[1:0] == CMD_READ ? read_word << (BITS_24 - reg_bits(rd_addr)) : 24'h000000;

	always_ff @(posedge clock) begin
		if (rst) begin
			sclk_q <= 1'b0;
			bit_cnt <= 6'h00;
			cmd <= 8'h00;
			shift_in <= 24'h000000;
			shift_out <= 24'h000000;
			spi_miso <= 1'b0;
			spi_miso_oe <= 1'b0;
		end else begin
			sclk_q <= spi_sclk;
			spi_miso_oe <= !spi_cs_n;
			if (spi_cs_n) begin
				bit_cnt <= 6'h00;
			end else if (rise) begin
				shift_in <= in_word[23:0];
				bit_cnt <= bit_cnt + 6'h01;
				if (bit_cnt == CMD_BITS - 6'h01) begin
					cmd <= in_word[7:0];
					shift_out <= read_aligned;
				end
			end else if (fall) begin
				spi_miso <= shift_out[23];
				shift_out <= shift_out << 1;
			end
		end
	end

	// register writes never touch the held result
	always_ff @(posedge clock) begin
		if (rst) begin
			third_config_register <= THIRD_CONFIG_REGISTER_RESET;
			offset_correction_value <= OFFSET_RESET;
			gain_correction_value <= GAIN_RESET;
			scan_timer <= TIMER_RESET;
		end else if (wr_fire) begin
			case (cmd_addr)
				REG_THIRD_CONFIG_REGISTER: third_config_register <= in_word[7:0];
				REG_OFFSET: offset_correction_value <= in_word[23:0];
				REG_GAIN: gain_correction_value <= in_word[23:0];
				REG_TIMER: scan_timer <= in_word[23:0];
				default: third_config_register <= third_config_register;
			endcase
		end
	end

	// sequencer
	wire [23:0] conv_len = auto_zero_swap_enable ? conv_cycles << 1 : conv_cycles;
	wire conv_end = state == ST_CONV && cnt == 24'h000001 && adc_mode[1];
	wire scan_more = scan_en && scan_idx != scan_last;
	wire cont = conversion_sequencing_select == MODE_CONV;
	wire one_end = conv_end && !scan_more && !cont;
	wire gap_go = conv_end && !scan_more && cont && scan_en && scan_timer != 24'h000000;
	wire restart = conv_end && (scan_more || (cont && (scan_en ? scan_timer == 24'h000000
		: auto_zero_swap_enable)));
	wire run_on = conv_end && !scan_more && cont && !scan_en && !auto_zero_swap_enable;
	wire to_shut = !adc_mode[1] && state != ST_SHUT;
	wire start_conv = next_state == ST_CONV && (state != ST_CONV || restart);

	always_comb begin
		next_state = state;
		case (state)
			ST_SHUT: if (adc_mode[1]) next_state = ST_WARM;
			ST_WARM: if (cnt == 24'h000001) next_state = adc_mode == MODE_CONV ? ST_CONV : ST_IDLE;
			ST_IDLE: if (adc_mode == MODE_CONV) next_state = ST_CONV;
			ST_CONV: begin
				if (one_end)
					next_state = conversion_sequencing_select[1] ? ST_IDLE : ST_SHUT;
				else if (gap_go)
					next_state = ST_GAP;
			end
			ST_GAP: if (cnt <= 24'h000001) next_state = ST_CONV;
			default: next_state = ST_SHUT;
		endcase
		if (to_shut)
			next_state = ST_SHUT;
	end

	assign next_cnt = next_state == ST_SHUT ? STARTUP_CYCLES
		: (start_conv || run_on) ? conv_len
		: gap_go ? scan_timer
		: (state != ST_IDLE && state != ST_SHUT && cnt != 24'h000000) ? cnt - 24'h000001
		: cnt;

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= ST_SHUT;
			cnt <= STARTUP_CYCLES;
			scan_idx <= 4'h0;
			modulator_enable <= 1'b0;
			conversion_strobe <= 1'b0;
			filter_clear <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			modulator_enable <= next_state == ST_CONV;
			conversion_strobe <= conv_end;
			filter_clear <= start_conv;
			if (conv_end)
				scan_idx <= scan_more ? scan_idx + 4'h1 : 4'h0;
			else if (state != ST_CONV && state != ST_GAP)
				scan_idx <= 4'h0;
		end
	end

	// converter-state field follows the end of a one-shot
	always_ff @(posedge clock) begin
		if (rst) begin
			adc_mode <= CONTROL_RESET[1:0];
			auto_zero_swap_enable <= CONTROL_RESET[CTL_AZ];
			scan_en <= CONTROL_RESET[CTL_SCAN];
			scan_last <= CONTROL_RESET[CTL_LAST_LSB +: 4];
		end else if (ctl_wr) begin
			adc_mode <= in_word[1:0];
			auto_zero_swap_enable <= in_word[CTL_AZ];
			scan_en <= in_word[CTL_SCAN];
			scan_last <= in_word[CTL_LAST_LSB +: 4];
		end else if (one_end) begin
			adc_mode <= conversion_sequencing_select[1] ? MODE_STANDBY : MODE_SHUT;
		end
	end

	// correction datapath
	acm_fifo #(
		.WIDTH(RAW_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.in_valid(raw_valid),
		.in_data(raw_data),
		.in_ready(raw_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(!gain_busy)
	);

	wire pop = fifo_valid && !gain_busy;
	wire off_now = third_config_register[CFG_OFF_EN];
	wire gain_now = third_config_register[CFG_GAIN_EN];
	wire [15:0] off_val = off_now ? offset_correction_value[23:8] : 16'h0000;
	wire signed [16:0] raw_sum = $signed({fifo_data[15], fifo_data}) + $signed({off_val[15], off_val});
	wire [15:0] g_val = gain_correction_value[23:8];
	wire signed [33:0] acc_next = acc + gain_term(sum_q, g_q, bit_i);
	wire gain_done = gain_busy && bit_i == GAIN_LAST_BIT;
	wire result_wr = (pop && !gain_now) || gain_done;
	wire signed [33:0] wide = gain_done ? acc_next >>> GAIN_FRAC : 34'(raw_sum);
	wire [16:0] sat = sat16(wide);

	always_ff @(posedge clock) begin
		if (rst) begin
			gain_busy <= 1'b0;
			bit_i <= 4'h0;
			sum_q <= '0;
			g_q <= 16'h0000;
			acc <= '0;
		end else if (pop && gain_now) begin
			gain_busy <= 1'b1;
			sum_q <= raw_sum;
			g_q <= g_val;
			acc <= gain_term(raw_sum, g_val, 4'h0);
			bit_i <= 4'h1;
		end else if (gain_busy) begin
			acc <= acc_next;
			bit_i <= bit_i + 4'h1;
			if (gain_done)
				gain_busy <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			conversion_result <= 16'h0000;
			overload <= 1'b0;
			data_ready_n <= 1'b1;
			hold <= 5'h00;
		end else if (result_wr) begin
			{overload, conversion_result} <= sat;
			data_ready_n <= 1'b0;
			hold <= IRQ_HOLD;
		end else begin
			if (rd_done || (cont && hold == 5'h01))
				data_ready_n <= 1'b1;
			if (hold != 5'h00)
				hold <= hold - 5'h01;
		end
	end

	logic [8:0] warm_len;
	always_ff @(posedge clock) begin
		if (rst || state != ST_WARM)
			warm_len <= 9'h000;
		else
			warm_len <= warm_len + 9'h001;
	end

	a_shut_reload: assert property (@(posedge clock) disable iff (rst)
		$past(state) == ST_SHUT && state == ST_SHUT |-> cnt == STARTUP_CYCLES)
		else $error("startup count not reloaded in shutdown");
	a_warm_length: assert property (@(posedge clock) disable iff (rst)
		state == ST_WARM && next_state != ST_WARM && !to_shut |-> warm_len == 9'h0FF)
		else $error("startup wait is not 256 clocks");
	a_offset_no_delay: assert property (@(posedge clock) disable iff (rst)
		pop && !gain_now |=> !data_ready_n && conversion_result == $past(sat[15:0]))
		else $error("offset path added latency");
	a_gain_latency: assert property (@(posedge clock) disable iff (rst)
		pop && gain_now |-> ##1 (!result_wr)[*8] ##1 (!result_wr)[*6] ##1 result_wr)
		else $error("gain result not written after 15 clocks");
	a_result_held: assert property (@(posedge clock) disable iff (rst)
		!result_wr |=> $stable(conversion_result))
		else $error("held result changed without a new result");
	a_irq_oneshot: assert property (@(posedge clock) disable iff (rst)
		!data_ready_n && !cont && !rd_done |=> !data_ready_n)
		else $error("one-shot data ready dropped before full read");
	a_oneshot_shut: assert property (@(posedge clock) disable iff (rst)
		one_end && !conversion_sequencing_select[1] && !ctl_wr |=> state == ST_SHUT && adc_mode == MODE_SHUT)
		else $error("mode 0x did not return to shutdown");
	a_oneshot_standby: assert property (@(posedge clock) disable iff (rst)
		one_end && conversion_sequencing_select == MODE_STANDBY && !ctl_wr |=> state == ST_IDLE && adc_mode == MODE_STANDBY)
		else $error("mode 10 did not return to standby");
	a_continuous_run: assert property (@(posedge clock) disable iff (rst)
		state == ST_CONV && cont && !scan_en && !auto_zero_swap_enable && adc_mode == MODE_CONV && !ctl_wr
		|=> state == ST_CONV && adc_mode == MODE_CONV && !filter_clear)
		else $error("continuous mode left conversion or reset filter");
	a_conv_length: assert property (@(posedge clock) disable iff (rst)
		start_conv |=> cnt == ($past(auto_zero_swap_enable) ? conv_cycles << 1 : conv_cycles))
		else $error("conversion length wrong");
	a_clamp_flag: assert property (@(posedge clock) disable iff (rst)
		result_wr && (wide > SAT_HI || wide < SAT_LO) |=> overload)
		else $error("out of range result not flagged");
endmodule

// >>> acm_host.sv
// host side of the serial register port: mode 0 master, msb first
// assumes one clock; sclk is made from it with 3 clocks low and 2 high per bit
module acm_host (
	input wire logic clock,
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	import acm_pkg::*;
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_mosi = 1'b0;
	end
	function automatic int width_of(input logic [3:0] a);
		if (a == REG_RESULT) return 16;
		if (a == REG_TIMER || a == REG_OFFSET || a == REG_GAIN) return 24;
		return 8;
	endfunction
	// an undriven miso reads as unknown so a silent device never matches
	task automatic bit_step(input logic b, output logic s);
		spi_sclk <= 1'b0;
		spi_mosi <= b;
		repeat (3) @(posedge clock);
		s = spi_miso_oe ? spi_miso : 1'bx;
		spi_sclk <= 1'b1;
		repeat (2) @(posedge clock);
	endtask
	task automatic xfer(input logic [3:0] a, input logic [1:0] c, input logic [23:0] wd, output logic [23:0] rd);
		logic [7:0] cmd;
		logic s;
		int n;
		cmd = {2'h0, a, c};
		n = width_of(a);
		rd = 24'h000000;
		spi_cs_n <= 1'b0;
		@(posedge clock);
		for (int i = 7; i >= 0; i--) bit_step(cmd[i], s);
		// whole register is always clocked out, which is what clears data ready
		for (int i = n - 1; i >= 0; i--) begin
			bit_step(wd[i], s);
			rd[i] = s;
		end
		spi_cs_n <= 1'b1;
		spi_sclk <= 1'b0;
		spi_mosi <= ~spi_mosi;
		repeat (3) @(posedge clock);
	endtask
endmodule

// >>> acm_core_tb.sv
// self-checking bench of the correction and sequencing block
// assumes acm_host drives the serial port; raw samples come from the bench
module acm_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import acm_pkg::*;
`define CHECK(w, e, s) begin samples_checked++; if ((s) !== (e)) begin fails++; \
$display("wrong value %s expected %0h seen %0h", w, e, s); end end
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
	logic [RAW_W-1:0] raw_data = 16'h0000;
	logic raw_valid = 1'b0;
	logic raw_ready, modulator_enable, conversion_strobe, filter_clear, data_ready_n, overload;
	int fails = 0;
	int samples_checked = 0;
	int fm, ns, gp, nf, n;
	logic [23:0] q;
	logic [16:0] e;
	logic [15:0] t_raw [7] = '{16'h1234, 16'h1234, 16'h1234, 16'h1234, 16'h7000, 16'h7000, 16'h8000};
	logic [23:0] t_off [7] = '{24'h100055, 24'h100055, 24'h100055, 24'h100055, 24'h700000, 24'h0, 24'hF00000};
	logic [23:0] t_gain [7] = '{24'h4000AA, 24'h4000AA, 24'h4000AA, 24'h4000AA, 24'h400000, 24'hFFFF00, 24'h4000AA};
	logic [1:0] t_cfg [7] = '{2'h0, 2'h2, 2'h1, 2'h3, 2'h3, 2'h1, 2'h2};
	logic [3:0] r_addr [6] = '{REG_CONTROL, REG_THIRD_CONFIG_REGISTER, REG_OFFSET, REG_GAIN, REG_TIMER, 4'h5};
	logic [23:0] r_val [6] = '{{16'h0, CONTROL_RESET}, {16'h0, THIRD_CONFIG_REGISTER_RESET}, OFFSET_RESET, GAIN_RESET, TIMER_RESET, 24'h0};
	always #12.5 clock = ~clock;
	acm_core #(.conv_cycles(24'h000008)) i_acm_core (.clock(clock), .rst(rst), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
		.raw_data(raw_data), .raw_valid(raw_valid), .raw_ready(raw_ready), .modulator_enable(modulator_enable),
		.conversion_strobe(conversion_strobe), .filter_clear(filter_clear), .data_ready_n(data_ready_n),
		.overload(overload));
	acm_host i_acm_host (.clock(clock), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic hang;
		fails++;
		complete_run;
	endtask
	task automatic wr(input logic [3:0] a, input logic [23:0] d);
		logic [23:0] x;
		i_acm_host.xfer(a, CMD_WRITE, d, x);
	endtask
	task automatic rd(input logic [3:0] a, output logic [23:0] d);
		i_acm_host.xfer(a, CMD_READ, 24'h000000, d);
	endtask
	function automatic logic [16:0] model(input logic [15:0] r, input logic [23:0] o, g, input logic [1:0] c);
		logic signed [33:0] s;
		s = $signed(r);
		if (c[1]) s = s + $signed(o[23:8]);
		if (c[0]) s = (s * $signed({1'b0, g[23:8]})) >>> 15;
		if (s > 34'sh7FFF) return {1'b1, 16'h7FFF};
		if (s < -34'sh8000) return {1'b1, 16'h8000};
		return {1'b0, s[15:0]};
	endfunction
	task automatic push(input logic [15:0] v);
		int k;
		raw_data <= v;
		raw_valid <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge clock);
			if (raw_ready === 1'b1) break;
		end
		raw_valid <= 1'b0;
		if (k == 100) hang;
	endtask
	task automatic sample(input logic [15:0] r, input logic [23:0] o, g, input logic [1:0] c);
		wr(REG_OFFSET, o);
		wr(REG_GAIN, g);
		wr(REG_THIRD_CONFIG_REGISTER, {22'h000000, c});
		e = model(r, o, g, c);
		push(r);
		for (n = 0; n < 400; n++) begin
			@(posedge clock);
			if (data_ready_n === 1'b0) break;
		end
		if (n == 400) hang;
		`CHECK("latency", c[0] ? 16 : 1, n)
		`CHECK("overload", e[16], overload)
		repeat (40) @(posedge clock);
		`CHECK("held ready", 1'b0, data_ready_n)
		rd(REG_RESULT, q);
		`CHECK("result", e[15:0], q[15:0])
		`CHECK("ready cleared", 1'b1, data_ready_n)
	endtask
	task automatic watch(input int cyc);
		int last;
		fm = -1;
		ns = 0;
		gp = 0;
		nf = 0;
		last = 0;
		for (int i = 0; i < cyc; i++) begin
			@(posedge clock);
			if (modulator_enable === 1'b1 && fm < 0) fm = i;
			if (conversion_strobe === 1'b1) begin
				if (ns > 0) gp = i - last;
				last = i;
				ns++;
			end
			if (filter_clear === 1'b1) nf++;
		end
	endtask
	task automatic seq(input logic [7:0] cfg, ctl, input int cyc);
		wr(REG_THIRD_CONFIG_REGISTER, {16'h0, cfg});
		wr(REG_CONTROL, {16'h0, ctl});
		watch(cyc);
	endtask
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		foreach (r_addr[i]) begin
			rd(r_addr[i], q);
			`CHECK("reset value", r_val[i], q)
		end
		wr(REG_OFFSET, 24'hA5C3F0);
		rd(REG_OFFSET, q);
		`CHECK("offset reg", 24'hA5C3F0, q)
		wr(REG_GAIN, 24'h5A3C0F);
		rd(REG_GAIN, q);
		`CHECK("gain reg", 24'h5A3C0F, q)
		for (int i = 0; i < 7; i++) sample(t_raw[i], t_off[i], t_gain[i], t_cfg[i]);
		// new settings must not touch the held result
		wr(REG_THIRD_CONFIG_REGISTER, 24'h000003);
		wr(REG_OFFSET, 24'h123400);
		wr(REG_GAIN, 24'h200000);
		rd(REG_RESULT, q);
		`CHECK("held result", e[15:0], q[15:0])
		sample(16'h0100, 24'h123400, 24'h200000, 2'h3);
		// back-to-back samples while the gain unit stalls the buffer
		raw_valid <= 1'b1;
		raw_data <= 16'h0010;
		n = 0;
		for (int k = 0; k < 40; k++) begin
			@(posedge clock);
			if (raw_ready !== 1'b1) break;
			n++;
			raw_data <= 16'h0010 + n[15:0];
		end
		raw_valid <= 1'b0;
		`CHECK("fifo full", 1'b1, n >= 16 && n <= 19)
		repeat (500) @(posedge clock);
		e = model(16'h000F + n[15:0], 24'h123400, 24'h200000, 2'h3);
		rd(REG_RESULT, q);
		`CHECK("drained", e[15:0], q[15:0])
		seq(8'h00, 8'h03, 400);
		`CHECK("warm up", 1'b1, fm >= 250 && fm <= 258)
		`CHECK("one shot", 1, ns)
		rd(REG_CONTROL, q);
		`CHECK("to shutdown", 8'h00, q[7:0])
		seq(8'h80, 8'h03, 400);
		`CHECK("one shot", 1, ns)
		rd(REG_CONTROL, q);
		`CHECK("to standby", 8'h02, q[7:0])
		seq(8'hC0, 8'h03, 120);
		`CHECK("from standby", 1'b1, fm >= 0 && fm <= 4)
		`CHECK("continuous gap", 8, gp)
		`CHECK("no filter reset", 1'b1, nf <= 1)
		rd(REG_CONTROL, q);
		`CHECK("stays converting", 8'h03, q[7:0])
		wr(REG_CONTROL, 24'h000007);
		watch(150);
		`CHECK("swap gap", 16, gp)
		`CHECK("swap resets", 1'b1, nf >= 4)
		wr(REG_CONTROL, 24'h000000);
		seq(8'h00, 8'h1B, 400);
		`CHECK("scan cycle", 2, ns)
		rd(REG_CONTROL, q);
		`CHECK("scan shutdown", 8'h00, q[1:0])
		// repeating scan: one conversion of 8 clocks plus a timer gap of 10 clocks
		wr(REG_TIMER, 24'h00000A);
		seq(8'hC0, 8'h0B, 400);
		`CHECK("scan repeat gap", 18, gp)
		`CHECK("scan keeps cycling", 1'b1, ns >= 5)
		rd(REG_CONTROL, q);
		`CHECK("scan stays converting", 8'h0B, q[7:0])
		wr(REG_CONTROL, 24'h000000);
		complete_run;
	end
endmodule
